// ---- inc/bpsfe_defines.vh ----
// Shared widths, reset levels and state codes for the pin-state and numeric-error block.
`ifndef BPSFE_DEFINES_VH
`define BPSFE_DEFINES_VH

`define BPSFE_DATA_W        32
`define BPSFE_PAR_W         4
`define BPSFE_UADDR_W       28
`define BPSFE_LADDR_W       2
`define BPSFE_BE_W          4
`define BPSFE_ASYNC_W       8
`define BPSFE_SYNC_RST      1'b0
`define BPSFE_ST_RUN        1'b0
`define BPSFE_ST_STOP       1'b1
`define BPSFE_HIGH          1'b1
`define BPSFE_LOW           1'b0
`define BPSFE_ASYNC_RST_VAL 8'hff
`define BPSFE_SMP_RST_VAL   10'h3fe

`endif

// ---- rtl/bpsfe_sync.v ----
// Two-stage synchroniser bank for asynchronous pins.
`timescale 1ns/1ps
`include "bpsfe_defines.vh"

module bpsfe_sync #(
    parameter                      W       = 8,
    parameter [W-1:0]              RST_VAL = {W{1'b0}}
) (
    // Clock and reset.
    input  wire                    i_ref_clk,
    input  wire                    i_rst,
    // Raw and synchronised levels.
    input  wire [W-1:0]            i_async,
    output wire [W-1:0]            o_sync
);

    reg [W-1:0] meta;
    reg [W-1:0] stable;

    // The first stage feeds only the second stage.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= RST_VAL;
            stable <= RST_VAL;
        end else begin
            meta   <= i_async;
            stable <= meta;
        end
    end

    assign o_sync = stable;

endmodule

// ---- rtl/bpsfe_pin_ctrl.v ----
// Bus pin-state control and DOS-style numeric error signalling.
//
// Contract
// - Unmasked FP error drives error output low.
// - Masked FP errors leave error output high.
// - Error output never floats; holds in stop.
// - Ignore-error asserted: continue, still flag error.
// - Ignore-error released: freeze on next FP.
// - Native error bit overrides ignore-error input.
// - Previous-state outputs hold level in stop.
// - Locks and strobe high in stop, float hold.
// - Data and parity float in hold, stop.
// - Address floats in both holds, holds stop.
// - Enables, attributes, cycle, burst float bus hold.
// - Request, ack, parity, SMM always driven.
// - Listed inputs asynchronous; bus inputs sampled synchronously.
`timescale 1ns/1ps
`include "bpsfe_defines.vh"

module bpsfe_pin_ctrl (
    // Clock and reset.
    input  wire                        i_ref_clk,
    input  wire                        i_rst,
    // Asynchronous pins, active levels as on the pins.
    input  wire                        i_soft_reset_in,
    input  wire                        i_cache_flush_in_n,
    input  wire                        i_address_bit20_mask_in_n,
    input  wire                        i_maskable_interrupt_request,
    input  wire                        i_nmi_in,
    input  wire                        i_ignore_numeric_error_in_n,
    input  wire                        i_smm_interrupt_in_n,
    input  wire                        i_stop_clock_request_in_n,
    // Synchronous pins.
    input  wire                        i_hold_in,
    input  wire                        i_address_hold_in,
    input  wire                        i_external_snoop_strobe_in_n,
    input  wire                        i_backoff_in_n,
    input  wire                        i_bus_size_16_in_n,
    input  wire                        i_bus_size_8_in_n,
    input  wire                        i_cache_enable_in_n,
    input  wire                        i_ready_in_n,
    input  wire                        i_burst_ready_in_n,
    // Core status and control.
    input  wire                        i_bus_idle,
    input  wire                        i_core_data_drive,
    input  wire                        i_native_error_mode_bit,
    input  wire                        i_fp_error_event,
    input  wire                        i_fp_error_masked,
    input  wire                        i_fp_error_clear,
    input  wire                        i_fp_noncontrol_issue,
    // Core values for the bus pins.
    input  wire [`BPSFE_UADDR_W-1:0]   i_core_upper_address,
    input  wire [`BPSFE_LADDR_W-1:0]   i_core_low_address,
    input  wire [`BPSFE_DATA_W-1:0]    i_core_data,
    input  wire [`BPSFE_PAR_W-1:0]     i_core_parity,
    input  wire [`BPSFE_BE_W-1:0]      i_core_byte_enables_n,
    input  wire                        i_core_page_write_through,
    input  wire                        i_core_page_cache_disable,
    input  wire [2:0]                  i_core_cycle_def,
    input  wire                        i_core_bus_lock_n,
    input  wire                        i_core_pseudo_lock_n,
    input  wire                        i_core_address_strobe_n,
    input  wire                        i_core_burst_last_n,
    input  wire                        i_core_bus_request,
    input  wire                        i_core_parity_check_n,
    input  wire                        i_core_smm_active_n,
    // Synchronised and sampled inputs, stop and hold state and numeric-error requests toward the core.
    output wire [`BPSFE_ASYNC_W-1:0]   o_async_sync,
    output reg  [9:0]                  o_sync_sampled,
    output wire                        o_stop_grant_state,
    output wire                        o_bus_hold,
    output reg                         o_fp_freeze,
    output reg                         o_fp_exception_req,
    // Two-way data, parity and address pins.
    input  wire [`BPSFE_DATA_W-1:0]    i_data_bus_lines,
    output reg  [`BPSFE_DATA_W-1:0]    o_data_bus_lines,
    output reg                         o_data_bus_lines_oe_n,
    input  wire [`BPSFE_PAR_W-1:0]     i_data_parity_lines,
    output reg  [`BPSFE_PAR_W-1:0]     o_data_parity_lines,
    output reg                         o_data_parity_lines_oe_n,
    input  wire [`BPSFE_UADDR_W-1:0]   i_upper_address_lines,
    output reg  [`BPSFE_UADDR_W-1:0]   o_upper_address_lines,
    output reg                         o_address_oe_n,
    output reg  [`BPSFE_LADDR_W-1:0]   o_low_address_lines,
    // Floatable outputs and their shared enable.
    output reg  [`BPSFE_BE_W-1:0]      o_byte_enables_n,
    output reg                         o_page_write_through_out,
    output reg                         o_page_cache_disable_out,
    output reg  [2:0]                  o_cycle_def_out,
    output reg                         o_burst_last_out_n,
    output reg                         o_bus_lock_out_n,
    output reg                         o_pseudo_lock_out_n,
    output reg                         o_address_strobe_out_n,
    output reg                         o_bus_ctl_oe_n,
    // Always-driven outputs.
    output reg                         o_bus_request_out,
    output reg                         o_hold_ack_out,
    output reg                         o_parity_check_out_n,
    output reg                         o_smm_active_out_n,
    output reg                         o_fp_error_out_n
);

    wire [`BPSFE_ASYNC_W-1:0] async_raw;
    reg                       state;
    reg                       next_state;
    reg                       fp_pending;
    wire                      stop_req;
    wire                      ignore_err;
    wire                      backoff;

    assign async_raw = {i_stop_clock_request_in_n, i_smm_interrupt_in_n, i_ignore_numeric_error_in_n,
                        i_nmi_in, i_maskable_interrupt_request, i_address_bit20_mask_in_n,
                        i_cache_flush_in_n, i_soft_reset_in};

    // Reset values put the active-low pins at their inactive level.
    bpsfe_sync #(
        .W       (`BPSFE_ASYNC_W),
        .RST_VAL (`BPSFE_ASYNC_RST_VAL & 8'hfe)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   (async_raw),
        .o_sync    (o_async_sync)
    );

    assign stop_req   = ~o_async_sync[7];
    assign ignore_err = ~o_async_sync[5];

    // Bus-side inputs are already timed to this clock, so one sampling stage is enough.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sync_sampled <= `BPSFE_SMP_RST_VAL;
        end else begin
            o_sync_sampled <= {i_burst_ready_in_n, i_ready_in_n, i_cache_enable_in_n, i_bus_size_8_in_n,
                               i_bus_size_16_in_n, i_backoff_in_n, i_external_snoop_strobe_in_n,
                               i_address_hold_in, i_hold_in, `BPSFE_LOW};
        end
    end

    assign backoff            = ~o_sync_sampled[4];
    assign o_bus_hold         = o_hold_ack_out | backoff;
    assign o_stop_grant_state = (state == `BPSFE_ST_STOP);

    // Stop grant is only entered with the bus idle, so no cycle is cut short.
    always @* begin
        case (state)
            `BPSFE_ST_RUN: begin
                next_state = (stop_req && i_bus_idle) ? `BPSFE_ST_STOP : `BPSFE_ST_RUN;
            end
            `BPSFE_ST_STOP: begin
                next_state = stop_req ? `BPSFE_ST_STOP : `BPSFE_ST_RUN;
            end
            default: begin
                next_state = `BPSFE_ST_RUN;
            end
        endcase
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= `BPSFE_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Pending numeric error; a new unmasked event wins over a clear in the same cycle.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fp_pending         <= `BPSFE_LOW;
            o_fp_freeze        <= `BPSFE_LOW;
            o_fp_exception_req <= `BPSFE_LOW;
        end else begin
            if (i_fp_error_event && !i_fp_error_masked) begin
                fp_pending <= `BPSFE_HIGH;
            end else if (i_fp_error_clear) begin
                fp_pending <= `BPSFE_LOW;
            end
            o_fp_freeze        <= fp_pending && i_fp_noncontrol_issue &&
                                  (i_native_error_mode_bit || !ignore_err);
            o_fp_exception_req <= fp_pending && i_fp_noncontrol_issue && i_native_error_mode_bit;
        end
    end

    // Always-driven outputs; hold acknowledge keeps tracking hold in stop grant.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bus_request_out    <= `BPSFE_LOW;
            o_hold_ack_out       <= `BPSFE_LOW;
            o_parity_check_out_n <= `BPSFE_HIGH;
            o_smm_active_out_n   <= `BPSFE_HIGH;
            o_fp_error_out_n     <= `BPSFE_HIGH;
        end else begin
            o_hold_ack_out <= o_sync_sampled[1] && (i_bus_idle || o_hold_ack_out);
            if (next_state == `BPSFE_ST_RUN) begin
                o_bus_request_out    <= i_core_bus_request;
                o_parity_check_out_n <= i_core_parity_check_n;
                o_smm_active_out_n   <= i_core_smm_active_n;
                o_fp_error_out_n     <= ~fp_pending;
            end
        end
    end

    // Floatable outputs: values frozen in stop grant, except the forced-high group.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_upper_address_lines    <= {`BPSFE_UADDR_W{1'b0}};
            o_low_address_lines      <= {`BPSFE_LADDR_W{1'b0}};
            o_data_bus_lines         <= {`BPSFE_DATA_W{1'b0}};
            o_data_parity_lines      <= {`BPSFE_PAR_W{1'b0}};
            o_byte_enables_n         <= {`BPSFE_BE_W{1'b1}};
            o_page_write_through_out <= `BPSFE_LOW;
            o_page_cache_disable_out <= `BPSFE_LOW;
            o_cycle_def_out          <= 3'h0;
            o_burst_last_out_n       <= `BPSFE_HIGH;
            o_bus_lock_out_n         <= `BPSFE_HIGH;
            o_pseudo_lock_out_n      <= `BPSFE_HIGH;
            o_address_strobe_out_n   <= `BPSFE_HIGH;
        end else if (next_state == `BPSFE_ST_STOP) begin
            o_bus_lock_out_n       <= `BPSFE_HIGH;
            o_pseudo_lock_out_n    <= `BPSFE_HIGH;
            o_address_strobe_out_n <= `BPSFE_HIGH;
        end else begin
            o_upper_address_lines    <= i_core_upper_address;
            o_low_address_lines      <= i_core_low_address;
            o_data_bus_lines         <= i_core_data;
            o_data_parity_lines      <= i_core_parity;
            o_byte_enables_n         <= i_core_byte_enables_n;
            o_page_write_through_out <= i_core_page_write_through;
            o_page_cache_disable_out <= i_core_page_cache_disable;
            o_cycle_def_out          <= i_core_cycle_def;
            o_burst_last_out_n       <= i_core_burst_last_n;
            o_bus_lock_out_n         <= i_core_bus_lock_n;
            o_pseudo_lock_out_n      <= i_core_pseudo_lock_n;
            o_address_strobe_out_n   <= i_core_address_strobe_n;
        end
    end

    // Output enables, low while driving. Reset floats the bus until the state settles.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_bus_lines_oe_n    <= `BPSFE_HIGH;
            o_data_parity_lines_oe_n <= `BPSFE_HIGH;
            o_address_oe_n           <= `BPSFE_HIGH;
            o_bus_ctl_oe_n           <= `BPSFE_HIGH;
        end else begin
            o_data_bus_lines_oe_n    <= o_bus_hold || next_state == `BPSFE_ST_STOP || !i_core_data_drive;
            o_data_parity_lines_oe_n <= o_bus_hold || next_state == `BPSFE_ST_STOP || !i_core_data_drive;
            o_address_oe_n           <= o_bus_hold || o_sync_sampled[2];
            o_bus_ctl_oe_n           <= o_bus_hold;
        end
    end

endmodule

// ---- verification/bpsfe_pin_ctrl_monitor.sv ----
// Concurrent checks on the pin-state and numeric-error block.
`timescale 1ns/1ps
module bpsfe_pin_ctrl_monitor (
    // Clock and reset.
    input wire        i_ref_clk,
    input wire        i_rst,
    // Watched inputs.
    input wire        i_fp_error_event,
    input wire        i_fp_error_masked,
    input wire        i_ignore_numeric_error_in_n,
    // Watched outputs.
    input wire [7:0]  o_async_sync,
    input wire [9:0]  o_sync_sampled,
    input wire        o_stop_grant_state,
    input wire        o_bus_hold,
    input wire        o_data_bus_lines_oe_n,
    input wire        o_address_oe_n,
    input wire        o_bus_ctl_oe_n,
    input wire [27:0] o_upper_address_lines,
    input wire        o_bus_lock_out_n,
    input wire        o_hold_ack_out,
    input wire        o_fp_error_out_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence err_s; i_fp_error_event && !i_fp_error_masked; endsequence
    sequence hold_s; o_bus_hold && !o_stop_grant_state; endsequence
    err_set_a: assert property (err_s |-> ##2 (!o_fp_error_out_n || o_stop_grant_state))
        else $error("error pin idle after error");
    err_mask_a: assert property ($fell(o_fp_error_out_n) |-> $past(i_fp_error_event && !i_fp_error_masked, 2))
        else $error("error pin low without error");
    stop_hold_a: assert property (o_stop_grant_state |-> $stable(o_fp_error_out_n) && $stable(o_upper_address_lines))
        else $error("level moved in stop");
    stop_force_a: assert property (o_stop_grant_state |-> o_bus_lock_out_n && o_data_bus_lines_oe_n)
        else $error("lock or data driven in stop");
    address_hold_in_float_a: assert property (o_sync_sampled[2] |=> o_address_oe_n)
        else $error("address driven in address hold");
    hold_float_a: assert property (hold_s |=> o_stop_grant_state || (o_bus_ctl_oe_n && o_data_bus_lines_oe_n))
        else $error("bus driven in bus hold");
    hold_ack_a: assert property (!o_sync_sampled[1] |=> !o_hold_ack_out)
        else $error("hold ack without hold");
    sync_two_a: assert property (o_async_sync[5] == $past(i_ignore_numeric_error_in_n, 2))
        else $error("sync latency wrong");
endmodule

bind bpsfe_pin_ctrl bpsfe_pin_ctrl_monitor mon (.*);

// ---- verification/bpsfe_chipset_model.sv ----
// Chipset-side model driving the synchronous hold and bus-status pins.
`timescale 1ns/1ps
module bpsfe_chipset_model (
    // Clock and reset.
    input  wire       i_ref_clk,
    input  wire       i_rst,
    // Requests and the processor answer.
    input  wire       i_want_hold,
    input  wire       i_want_address_hold_in,
    input  wire       i_hold_ack,
    // Synchronous pins.
    output reg        o_hold,
    output reg        o_address_hold_in,
    output reg  [5:0] o_misc_n
);
    integer seed = 32'h0bad5eed;
    // Hold stays up until acknowledged so that a short request is never lost.
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {o_hold, o_address_hold_in, o_misc_n} <= 8'h3f;
        end else begin
            o_hold   <= i_want_hold | (o_hold & ~i_hold_ack);
            o_address_hold_in  <= i_want_address_hold_in;
            o_misc_n <= 6'($random(seed));
        end
    end
endmodule

// ---- verification/bpsfe_pin_ctrl_test.sv ----
// Self-checking test of the pin-state and numeric-error block.
`timescale 1ns/1ps
module bpsfe_pin_ctrl_test;
    reg         i_ref_clk = 0, i_rst = 1, i_soft_reset_in, i_cache_flush_in_n, i_address_bit20_mask_in_n, i_nmi_in,
                i_maskable_interrupt_request, i_ignore_numeric_error_in_n, i_smm_interrupt_in_n, i_bus_idle = 1,
                i_stop_clock_request_in_n, i_backoff_in_n = 1, i_core_data_drive = 1, i_native_error_mode_bit,
                i_fp_error_event, i_fp_error_masked, i_fp_error_clear, i_fp_noncontrol_issue, i_core_bus_request,
                i_core_page_write_through, i_core_page_cache_disable, i_core_bus_lock_n, i_core_pseudo_lock_n,
                i_core_address_strobe_n, i_core_burst_last_n, i_core_parity_check_n, i_core_smm_active_n,
                want_hold, want_address_hold_in;
    reg  [31:0] i_core_data, i_data_bus_lines = 0;
    reg  [27:0] i_core_upper_address, i_upper_address_lines = 0, ea;
    reg  [3:0]  i_core_parity, i_data_parity_lines = 0, i_core_byte_enables_n;
    reg  [2:0]  i_core_cycle_def;
    reg  [1:0]  i_core_low_address;
    reg  [95:0] r;
    wire        i_hold_in, i_address_hold_in, i_external_snoop_strobe_in_n, i_bus_size_16_in_n, i_bus_size_8_in_n,
                i_cache_enable_in_n, i_ready_in_n, i_burst_ready_in_n, o_stop_grant_state, o_bus_hold, o_fp_freeze,
                o_fp_exception_req, o_data_bus_lines_oe_n, o_data_parity_lines_oe_n, o_address_oe_n,
                o_page_write_through_out, o_page_cache_disable_out, o_burst_last_out_n, o_bus_lock_out_n,
                o_pseudo_lock_out_n, o_address_strobe_out_n, o_bus_ctl_oe_n, o_bus_request_out, o_hold_ack_out,
                o_parity_check_out_n, o_smm_active_out_n, o_fp_error_out_n;
    wire [31:0] o_data_bus_lines;
    wire [27:0] o_upper_address_lines;
    wire [9:0]  o_sync_sampled;
    wire [7:0]  o_async_sync;
    wire [3:0]  o_data_parity_lines, o_byte_enables_n;
    wire [2:0]  o_cycle_def_out;
    wire [1:0]  o_low_address_lines;
    integer     seed = 32'h54ba55ae, errors = 0, total_checks = 0, k;

    bpsfe_pin_ctrl dut (.*);
    bpsfe_chipset_model far (.i_ref_clk, .i_rst, .i_want_hold(want_hold), .i_want_address_hold_in(want_address_hold_in),
        .i_hold_ack(o_hold_ack_out), .o_hold(i_hold_in), .o_address_hold_in(i_address_hold_in),
        .o_misc_n({i_burst_ready_in_n, i_ready_in_n, i_cache_enable_in_n, i_bus_size_8_in_n, i_bus_size_16_in_n,
                   i_external_snoop_strobe_in_n}));

    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #20000;
        errors = errors + 1;
        final_report;
    end
    task w(input integer n);
        begin
            repeat (n) @(posedge i_ref_clk);
            #1;
        end
    endtask
    task chk(input string name, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("FAIL %0s expected %h seen %h", name, e, g);
            end
        end
    endtask
    task ev(input m);
        begin
            i_fp_error_masked <= m;
            i_fp_error_event <= 1;
            w(1);
            i_fp_error_event <= 0;
            w(1);
        end
    endtask
    task clr;
        begin
            i_fp_error_clear <= 1;
            w(1);
            i_fp_error_clear <= 0;
            w(1);
        end
    endtask
    task rc;
        begin
            r = {$random(seed), $random(seed), $random(seed)};
            {i_core_upper_address, i_core_low_address, i_core_data, i_core_parity, i_core_byte_enables_n,
             i_core_cycle_def, i_core_page_write_through, i_core_page_cache_disable, i_core_bus_lock_n,
             i_core_pseudo_lock_n, i_core_address_strobe_n, i_core_burst_last_n, i_core_bus_request,
             i_core_parity_check_n, i_core_smm_active_n} <= r[81:0];
        end
    endtask
    task final_report;
        begin
            $display("errors %0d checks %0d", errors, total_checks);
            if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        {i_soft_reset_in, i_maskable_interrupt_request, i_nmi_in, i_native_error_mode_bit, i_fp_error_event,
         i_fp_error_masked, i_fp_error_clear, i_fp_noncontrol_issue, want_hold, want_address_hold_in} = 10'h000;
        {i_cache_flush_in_n, i_address_bit20_mask_in_n, i_ignore_numeric_error_in_n, i_smm_interrupt_in_n,
         i_stop_clock_request_in_n} = 5'h1f;
        rc;
        w(3);
        i_rst <= 0;
        w(2);
        for (k = 0; k < 12; k = k + 1) begin
            ev(r[k]);
            chk("fp_error_out", i_fp_error_masked, o_fp_error_out_n);
            clr;
            chk("fp_error_out_clr", 1, o_fp_error_out_n);
        end
        // Every pairing of native mode and ignore-error level.
        for (k = 0; k < 4; k = k + 1) begin
            {i_native_error_mode_bit, i_ignore_numeric_error_in_n} <= k[1:0];
            ev(0);
            w(2);
            i_fp_noncontrol_issue <= 1;
            w(1);
            i_fp_noncontrol_issue <= 0;
            chk("freeze", k != 0, o_fp_freeze);
            chk("native", k[1], o_fp_exception_req);
            chk("fp_error_out_ign", 0, o_fp_error_out_n);
            clr;
        end
        {i_native_error_mode_bit, i_ignore_numeric_error_in_n} <= 2'h1;
        ev(0);
        ea = i_core_upper_address;
        i_stop_clock_request_in_n <= 0;
        w(4);
        chk("stop", 1, o_stop_grant_state);
        rc;
        want_hold <= 1;
        clr;
        w(4);
        chk("addr", ea, o_upper_address_lines);
        chk("fp_error_out_stop", 0, o_fp_error_out_n);
        chk("forced", 5'h1f, {o_bus_lock_out_n, o_pseudo_lock_out_n, o_address_strobe_out_n,
            o_data_bus_lines_oe_n, o_data_parity_lines_oe_n});
        chk("hold_ack_out", 1, o_hold_ack_out);
        want_hold <= 0;
        i_stop_clock_request_in_n <= 1;
        w(6);
        chk("run", 0, {o_stop_grant_state, o_hold_ack_out});
        chk("addr_run", i_core_upper_address, o_upper_address_lines);
        chk("fp_error_out_run", 1, o_fp_error_out_n);
        want_address_hold_in <= 1;
        w(3);
        chk("address_hold_in_oe", 3'h4, {o_address_oe_n, o_data_bus_lines_oe_n, o_bus_ctl_oe_n});
        want_address_hold_in <= 0;
        want_hold <= 1;
        w(6);
        chk("hold_oe", 4'hf, {o_address_oe_n, o_data_bus_lines_oe_n, o_data_parity_lines_oe_n,
            o_bus_ctl_oe_n});
        chk("bus_request_out", i_core_bus_request, o_bus_request_out);
        want_hold <= 0;
        w(6);
        // Backoff alone must float the bus group as a bus hold does.
        i_backoff_in_n <= 0;
        w(2);
        chk("backoff_in_oe", 3'h7, {o_bus_ctl_oe_n, o_data_bus_lines_oe_n, o_address_oe_n});
        i_backoff_in_n <= 1;
        w(2);
        chk("backoff_in_run", 2'h0, {o_bus_ctl_oe_n, o_data_bus_lines_oe_n});
        for (k = 0; k < 10; k = k + 1) begin
            r = {3{$random(seed)}};
            {i_soft_reset_in, i_maskable_interrupt_request, i_nmi_in, i_smm_interrupt_in_n,
             i_address_bit20_mask_in_n, i_cache_flush_in_n} <= r[5:0];
            w(2);
            chk("sync", {1'b1, r[2], 1'b1, r[3], r[4], r[1], r[0], r[5]}, o_async_sync);
        end
        final_report;
    end
endmodule
